// File: core/cct_pkg.sv
package cct_pkg;

    // ==================================================================
    // Timing, derived from the 100 MHz reference clock
    // ==================================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int STOP_ACK_DELAY = 20;
    localparam int MAX_OFF_NS = 3000;
    localparam int MAX_OFF_CYC = MAX_OFF_NS / CLK_PERIOD_NS;
    localparam int PLL_SETTLE_US = 1000;
    localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * 1000 / CLK_PERIOD_NS;
    localparam int DEEP_MIN_US = 25;
    localparam int DEEP_MIN_CYC = DEEP_MIN_US * 1000 / CLK_PERIOD_NS;

    // ==================================================================
    // Clock modulation
    // ==================================================================
    localparam int DUTY_W = 3;
    localparam int DUTY_STEPS = 8;
    // Longest off stretch is seven slots, so a slot is a seventh of it.
    localparam int SLOT_CYC = MAX_OFF_CYC / (DUTY_STEPS - 1);
    localparam logic [DUTY_W-1:0] DUTY_AUTO = 3'h4;
    localparam logic [DUTY_W-1:0] DUTY_RESERVED = 3'h0;

    // ==================================================================
    // Pin synchroniser slots
    // ==================================================================
    localparam int PIN_W = 9;
    localparam int PIN_HALT_REQ_N = 0;
    localparam int PIN_SLEEP_REQ_N = 1;
    localparam int PIN_BCLK_RUN = 2;
    localparam int PIN_SNOOP = 3;
    localparam int PIN_SNOOP_DONE = 4;
    localparam int PIN_NEAR_LIMIT = 5;
    localparam int PIN_NON_CRIT = 6;
    localparam int PIN_CATASTROPHIC = 7;
    localparam int PIN_INTR = 8;
    // Idle levels: both requests released and the bus clock running.
    localparam logic [PIN_W-1:0] PIN_IDLE = 9'h007;

    typedef enum logic [3:0] {
        ST_NORMAL,
        ST_HALT,
        ST_STOP_PEND,
        ST_STOP_WAIT,
        ST_STOP_ACK,
        ST_SNOOP_HALT,
        ST_SNOOP_ACK,
        ST_SLEEP,
        ST_DEEP,
        ST_SETTLE
    } cct_state_t;

endpackage

// File: core/cct_mod_if.sv
interface cct_mod_if;
    import cct_pkg::*;
    logic active;
    logic [DUTY_W-1:0] duty;
    logic clk_on;
    modport ctrl (output active, output duty, input clk_on);
    modport gen (input active, input duty, output clk_on);
endinterface

// File: core/cct_modulator.sv
module cct_modulator
    import cct_pkg::*;
#(
    parameter int SLOT_CYCLES = SLOT_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    cct_mod_if.gen mod
);

    localparam int SW = $clog2(SLOT_CYCLES + 1);

    initial
    begin
        if (SLOT_CYCLES < 1 || SLOT_CYCLES * (DUTY_STEPS - 1) > MAX_OFF_CYC)
            $error("slot length cannot keep the off stretch in bounds");
    end

    logic [SW-1:0] slot_r;
    logic [DUTY_W-1:0] phase_r;

    // ==================================================================
    // Slot and phase counters
    // ==================================================================
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_r <= '0;
            phase_r <= '0;
        end
        else if (!mod.active)
        begin
            slot_r <= '0;
            phase_r <= '0;
        end
        else if (slot_r == SW'(SLOT_CYCLES - 1))
        begin
            slot_r <= '0;
            phase_r <= phase_r + 3'h1;
        end
        else
        begin
            slot_r <= slot_r + SW'(1);
        end
    end

    // Clocks run for the first duty eighths of each period.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mod.clk_on <= 1'b1;
        else
            mod.clk_on <= !mod.active || (phase_r < mod.duty);
    end

endmodule

// File: core/cct_top.sv
// Behaviour
// - Snoop in halt/stop-ack visits snoop state, returns.
// - Sleep from stop-ack on sleep request, or from settle.
// - Asleep: no snoop answer, no interrupt latching.
// - Reset in sleep resets directly; requests drop.
// - Bus clock stop in sleep enters deep sleep.
// - Deep sleep: static bus, no snoops, no interrupts.
// - Auto throttle at fixed half duty, bounded off.
// - Auto throttle ends after cool plus hysteresis.
// - On-demand enable starts modulation immediately.
// - Three-bit field sets on-time in eighths.
// - Hot auto duty overrides on-demand duty.
// - Hot output low whenever modulation active.
// - Snoops and interrupts continue while modulating.
// - Optional interrupt on hot assert and deassert.
// - Catastrophic heat trips shutdown until reset.
// - Stop-ack entered fixed clocks after acknowledge.
module cct_top
    import cct_pkg::*;
#(
    parameter int PLL_SETTLE_CYCLES = PLL_SETTLE_CYC,
    parameter int HYST_CYCLES = 1000
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clock_halt_request_n,
    input wire logic sleep_request_n,
    input wire logic bus_clock_running,
    input wire logic snoop_seen,
    input wire logic snoop_serviced,
    input wire logic die_near_limit,
    input wire logic die_non_critical,
    input wire logic die_catastrophic,
    input wire logic interrupt_in,
    input wire logic halt_enter,
    input wire logic wake_event,
    input wire logic stop_ack_done,
    input wire logic intr_ack,
    input wire logic auto_enable,
    input wire logic ondemand_enable,
    input wire logic [DUTY_W-1:0] ondemand_duty,
    input wire logic hot_irq_on_assert,
    input wire logic hot_irq_on_deassert,
    output cct_state_t power_state,
    output logic core_clk_en,
    output logic die_hot_n,
    output logic thermal_shutdown_n,
    output logic hot_irq,
    output logic snoop_respond,
    output logic intr_pending
);

    localparam int PW = $clog2(PLL_SETTLE_CYCLES + 1);
    localparam int HW = $clog2(HYST_CYCLES + 1);

    initial
    begin
        if (PLL_SETTLE_CYCLES < 1 || HYST_CYCLES < 1)
            $error("settle and hysteresis counts must be at least one");
    end

    // ==================================================================
    // Pin synchronisers
    // ==================================================================
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_s_r;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= PIN_IDLE;
            pin_s_r <= PIN_IDLE;
        end
        else
        begin
            pin_meta_r <= {interrupt_in, die_catastrophic, die_non_critical,
                           die_near_limit, snoop_serviced, snoop_seen,
                           bus_clock_running, sleep_request_n,
                           clock_halt_request_n};
            pin_s_r <= pin_meta_r;
        end
    end

    logic halt_req;
    logic sleep_req;
    logic bclk_run;
    logic asleep;
    assign halt_req = !pin_s_r[PIN_HALT_REQ_N];
    assign sleep_req = !pin_s_r[PIN_SLEEP_REQ_N];
    assign bclk_run = pin_s_r[PIN_BCLK_RUN];
    assign asleep = power_state inside {ST_SLEEP, ST_DEEP, ST_SETTLE};

    // ==================================================================
    // Low-power state machine
    // ==================================================================
    logic [4:0] stop_cnt_r;
    logic [PW-1:0] settle_cnt_r;
    logic from_halt_r;

    // Reset inside sleep lands in normal directly through rst_n.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_state <= ST_NORMAL;
            stop_cnt_r <= '0;
            settle_cnt_r <= '0;
            from_halt_r <= 1'b0;
        end
        else
        begin
            case (power_state)
                ST_NORMAL:
                    if (halt_req)
                    begin
                        power_state <= ST_STOP_PEND;
                        from_halt_r <= 1'b0;
                    end
                    else if (halt_enter)
                        power_state <= ST_HALT;
                ST_HALT:
                    if (halt_req)
                    begin
                        power_state <= ST_STOP_PEND;
                        from_halt_r <= 1'b1;
                    end
                    else if (pin_s_r[PIN_SNOOP])
                        power_state <= ST_SNOOP_HALT;
                    else if (wake_event)
                        power_state <= ST_NORMAL;
                ST_STOP_PEND:
                    if (stop_ack_done)
                    begin
                        power_state <= ST_STOP_WAIT;
                        stop_cnt_r <= 5'(STOP_ACK_DELAY - 2);
                    end
                ST_STOP_WAIT:
                    if (stop_cnt_r == 5'h00)
                        power_state <= ST_STOP_ACK;
                    else
                        stop_cnt_r <= stop_cnt_r - 5'h01;
                ST_STOP_ACK:
                    if (sleep_req)
                        power_state <= ST_SLEEP;
                    else if (pin_s_r[PIN_SNOOP])
                        power_state <= ST_SNOOP_ACK;
                    else if (!halt_req)
                        power_state <= from_halt_r ? ST_HALT : ST_NORMAL;
                ST_SNOOP_HALT:
                    if (pin_s_r[PIN_SNOOP_DONE])
                        power_state <= ST_HALT;
                ST_SNOOP_ACK:
                    if (pin_s_r[PIN_SNOOP_DONE])
                        power_state <= ST_STOP_ACK;
                ST_SLEEP:
                    if (!bclk_run)
                        power_state <= ST_DEEP;
                    else if (!sleep_req)
                        power_state <= ST_STOP_ACK;
                ST_DEEP:
                    if (bclk_run)
                    begin
                        power_state <= ST_SETTLE;
                        settle_cnt_r <= PW'(PLL_SETTLE_CYCLES - 1);
                    end
                ST_SETTLE:
                    if (!bclk_run)
                        power_state <= ST_DEEP;
                    else if (settle_cnt_r == '0)
                        power_state <= ST_SLEEP;
                    else
                        settle_cnt_r <= settle_cnt_r - PW'(1);
                default:
                    power_state <= ST_NORMAL;
            endcase
        end
    end

    // ==================================================================
    // Thermal control: automatic, on-demand, trip
    // ==================================================================
    logic auto_active_r;
    logic throttle_r;
    logic [HW-1:0] hyst_cnt_r;
    logic [DUTY_W-1:0] od_duty;
    cct_mod_if mod_if ();

    // Reserved zero falls back to half duty rather than stopping clocks.
    assign od_duty = (ondemand_duty == DUTY_RESERVED) ? DUTY_AUTO
                                                      : ondemand_duty;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_active_r <= 1'b0;
            hyst_cnt_r <= '0;
        end
        else if (!auto_enable)
            auto_active_r <= 1'b0;
        else if (pin_s_r[PIN_NEAR_LIMIT])
        begin
            auto_active_r <= 1'b1;
            hyst_cnt_r <= HW'(HYST_CYCLES);
        end
        else if (auto_active_r && pin_s_r[PIN_NON_CRIT])
        begin
            if (hyst_cnt_r == '0)
                auto_active_r <= 1'b0;
            else
                hyst_cnt_r <= hyst_cnt_r - HW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            throttle_r <= 1'b0;
            mod_if.duty <= DUTY_AUTO;
        end
        else
        begin
            throttle_r <= auto_active_r || ondemand_enable;
            mod_if.duty <= auto_active_r ? DUTY_AUTO : od_duty;
        end
    end

    assign mod_if.active = throttle_r;

    cct_modulator u_mod (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .mod(mod_if)
    );

    // Trip is sticky; only rst_n clears it.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            thermal_shutdown_n <= 1'b1;
        else if (pin_s_r[PIN_CATASTROPHIC])
            thermal_shutdown_n <= 1'b0;
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            die_hot_n <= 1'b1;
            hot_irq <= 1'b0;
            core_clk_en <= 1'b1;
            snoop_respond <= 1'b1;
        end
        else
        begin
            die_hot_n <= !throttle_r;
            hot_irq <= (throttle_r && die_hot_n && hot_irq_on_assert)
                || (!throttle_r && !die_hot_n && hot_irq_on_deassert);
            core_clk_en <= thermal_shutdown_n && !pin_s_r[PIN_CATASTROPHIC]
                && power_state == ST_NORMAL && mod_if.clk_on;
            snoop_respond <= !asleep && thermal_shutdown_n;
        end
    end

    // Interrupts latch while modulating but not while asleep; set wins.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            intr_pending <= 1'b0;
        else if (pin_s_r[PIN_INTR] && !asleep)
            intr_pending <= 1'b1;
        else if (intr_ack)
            intr_pending <= 1'b0;
    end

    // ==================================================================
    // Checks
    // ==================================================================
    logic [9:0] off_run_r;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            off_run_r <= '0;
        else if (mod_if.clk_on)
            off_run_r <= '0;
        else
            off_run_r <= off_run_r + 10'h001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    trip_sticky_a: assert property (!thermal_shutdown_n |=> !thermal_shutdown_n)
        else $error("shutdown output released without reset");
    hot_follow_a: assert property (throttle_r |=> !die_hot_n)
        else $error("hot output not asserted while modulating");
    sleep_entry_a: assert property ($rose(power_state == ST_SLEEP)
        |-> $past(power_state) inside {ST_STOP_ACK, ST_SETTLE})
        else $error("sleep entered from a wrong state");
    stop_delay_a: assert property (power_state == ST_STOP_PEND && stop_ack_done
        |-> ##20 power_state == ST_STOP_ACK)
        else $error("stop-ack not reached twenty clocks after acknowledge");
    snoop_return_a: assert property (power_state == ST_SNOOP_ACK
        && pin_s_r[PIN_SNOOP_DONE] |=> power_state == ST_STOP_ACK)
        else $error("snoop state did not return to stop-ack");
    sleep_snoop_a: assert property (asleep |=> !snoop_respond)
        else $error("snoop answered while asleep");
    deep_entry_a: assert property (power_state == ST_SLEEP && !bclk_run
        |=> power_state == ST_DEEP)
        else $error("deep sleep not entered on stopped bus clock");
    auto_duty_a: assert property (auto_active_r |=> mod_if.duty == DUTY_AUTO)
        else $error("automatic duty not applied while hot");
    max_off_a: assert property (off_run_r <= 10'(MAX_OFF_CYC))
        else $error("clocks held off too long");
    ondemand_a: assert property (ondemand_enable ##1 ondemand_enable
        |=> !mod_if.clk_on [*1] or mod_if.active)
        else $error("on-demand enable did not start modulation");
    irq_edge_a: assert property ($fell(die_hot_n) && hot_irq_on_assert
        && $past(hot_irq_on_assert) |-> hot_irq)
        else $error("no interrupt on hot assertion");

endmodule

// File: verif/cct_chipset.sv
module cct_chipset
    import cct_pkg::*;
#(
    parameter int DEEP_CYCLES = DEEP_MIN_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire cct_state_t power_state,
    output logic clock_halt_request_n,
    output logic sleep_request_n,
    output logic bus_clock_running,
    output logic snoop_seen,
    output logic snoop_serviced
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        clock_halt_request_n = 1'b1;
        sleep_request_n = 1'b1;
        bus_clock_running = 1'b1;
        snoop_seen = 1'b0;
        snoop_serviced = 1'b0;
    end

    // Requests left low across a reset would restart the sleep entry.
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            clock_halt_request_n <= 1'b1;
            sleep_request_n <= 1'b1;
        end
    end

    task automatic halt_req(input logic on);
        @(posedge ref_clk);
        clock_halt_request_n <= !on;
        #1;
    endtask

    task automatic sleep_req(input logic on);
        if (on && power_state !== ST_STOP_ACK)
            return;
        if (!on && power_state !== ST_SLEEP)
            return;
        @(posedge ref_clk);
        sleep_request_n <= !on;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // A stopped pair is parked low/high; the residency is timed here.
    task automatic bus_clock(input logic run);
        if (run)
            repeat (DEEP_CYCLES) @(posedge ref_clk);
        @(posedge ref_clk);
        bus_clock_running <= run;
        #1;
    endtask

    task automatic snoop(input logic start);
        if (power_state inside {ST_SLEEP, ST_DEEP, ST_SETTLE})
            return;
        @(posedge ref_clk);
        snoop_seen <= start;
        snoop_serviced <= !start;
        #1;
    endtask
endmodule

// File: verif/cct_top_tb_top.sv
module cct_top_tb_top
    import cct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SETTLE = 20;
    localparam int HYST = 10;
    localparam int PERIOD = DUTY_STEPS * SLOT_CYC;

    logic ref_clk, rst_n, halt_n, sleep_n, bclk_run, snoop, serviced;
    logic near, cool, trip, intr, auto_en, od_en, irq_a, irq_d;
    logic [DUTY_W-1:0] duty;
    logic [3:0] strobe;
    cct_state_t power_state;
    logic clk_en, hot_n, shut_n, hot_irq, snoop_resp, intr_pend;
    int err_count, samples_checked, irq_seen, seed, n;

    cct_top #(.PLL_SETTLE_CYCLES(SETTLE), .HYST_CYCLES(HYST)) u_cct_top (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clock_halt_request_n(halt_n),
        .sleep_request_n(sleep_n),
        .bus_clock_running(bclk_run),
        .snoop_seen(snoop),
        .snoop_serviced(serviced),
        .die_near_limit(near),
        .die_non_critical(cool),
        .die_catastrophic(trip),
        .interrupt_in(intr),
        .halt_enter(strobe[0]),
        .wake_event(strobe[1]),
        .stop_ack_done(strobe[2]),
        .intr_ack(strobe[3]),
        .auto_enable(auto_en),
        .ondemand_enable(od_en),
        .ondemand_duty(duty),
        .hot_irq_on_assert(irq_a),
        .hot_irq_on_deassert(irq_d),
        .power_state(power_state),
        .core_clk_en(clk_en),
        .die_hot_n(hot_n),
        .thermal_shutdown_n(shut_n),
        .hot_irq(hot_irq),
        .snoop_respond(snoop_resp),
        .intr_pending(intr_pend)
    );

    cct_chipset u_cct_chipset (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .power_state(power_state),
        .clock_halt_request_n(halt_n),
        .sleep_request_n(sleep_n),
        .bus_clock_running(bclk_run),
        .snoop_seen(snoop),
        .snoop_serviced(serviced)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (hot_irq === 1'b1)
            irq_seen++;

    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Sampling 1 ns after the edge keeps reads clear of the edge's updates.
    task automatic tick(input int cnt);
        repeat (cnt) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_st(input cct_state_t s, input int lim);
        n = 0;
        while (power_state !== s && n < lim)
        begin
            tick(1);
            n++;
        end
        check("power_state", power_state, s);
    endtask

    task automatic wait_hot(input logic v, input int lim);
        n = 0;
        while (hot_n !== v && n < lim)
        begin
            tick(1);
            n++;
        end
        check("die_hot_n", hot_n, v);
    endtask

    task automatic pulse(input int idx);
        @(posedge ref_clk);
        strobe[idx] <= 1'b1;
        @(posedge ref_clk);
        strobe[idx] <= 1'b0;
        #1;
    endtask

    task automatic snoop_visit(input cct_state_t busy, input cct_state_t home);
        u_cct_chipset.snoop(1'b1);
        wait_st(busy, 6);
        check("snoop answer", snoop_resp, 1'b1);
        tick($unsigned($random(seed)) % 8);
        u_cct_chipset.snoop(1'b0);
        wait_st(home, 6);
    endtask

    task automatic enter_sleep();
        u_cct_chipset.halt_req(1'b1);
        wait_st(ST_STOP_PEND, 8);
        pulse(2);
        wait_st(ST_STOP_ACK, 40);
        // The pulse task returns one edge after the acknowledge cycle began.
        check("stop ack delay", n + 1, STOP_ACK_DELAY);
        snoop_visit(ST_SNOOP_ACK, ST_STOP_ACK);
        u_cct_chipset.sleep_req(1'b1);
        wait_st(ST_SLEEP, 8);
    endtask

    // One whole modulation period holds exactly the programmed on share.
    task automatic measure(input int on_slots);
        int on_cnt;
        int run;
        int max_off;
        int cool_cnt;
        on_cnt = 0;
        run = 0;
        max_off = 0;
        cool_cnt = 0;
        repeat (PERIOD)
        begin
            tick(1);
            run = (clk_en === 1'b1) ? 0 : run + 1;
            on_cnt += int'(clk_en === 1'b1);
            max_off = (run > max_off) ? run : max_off;
            cool_cnt += int'(hot_n !== 1'b0);
        end
        check("on cycles", on_cnt, on_slots * SLOT_CYC);
        check("off stretch", max_off <= MAX_OFF_CYC, 1'b1);
        check("hot during run", cool_cnt, 0);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        conclude();
    end

    // ==================================================================
    // Scenarios
    // ==================================================================
    initial
    begin
        int off;
        int d;
        seed = 32'h3C55;
        {near, cool, trip, intr, auto_en, od_en, irq_a, irq_d} = 8'h00;
        duty = 3'h1;
        strobe = 4'h0;
        err_count = 0;
        samples_checked = 0;
        irq_seen = 0;
        rst_n = 1'b0;
        tick(20);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        check("reset outputs", {power_state, clk_en, hot_n, shut_n, hot_irq,
              snoop_resp, intr_pend}, {ST_NORMAL, 6'h3A});
        pulse(0);
        wait_st(ST_HALT, 6);
        snoop_visit(ST_SNOOP_HALT, ST_HALT);
        pulse(1);
        wait_st(ST_NORMAL, 6);
        enter_sleep();
        tick(1);
        check("sleep snoop answer", snoop_resp, 1'b0);
        @(posedge ref_clk);
        intr <= 1'b1;
        tick(5);
        check("sleep intr latch", intr_pend, 1'b0);
        @(posedge ref_clk);
        intr <= 1'b0;
        u_cct_chipset.bus_clock(1'b0);
        wait_st(ST_DEEP, 6);
        check("deep snoop answer", snoop_resp, 1'b0);
        u_cct_chipset.bus_clock(1'b1);
        wait_st(ST_SETTLE, 6);
        wait_st(ST_SLEEP, SETTLE + 4);
        check("settle length", n >= SETTLE - 2, 1'b1);
        u_cct_chipset.sleep_req(1'b0);
        wait_st(ST_STOP_ACK, 8);
        u_cct_chipset.halt_req(1'b0);
        wait_st(ST_NORMAL, 8);
        tick(1);
        check("clock on", clk_en, 1'b1);
        off = $unsigned($random(seed)) % DUTY_STEPS;
        for (int k = 0; k < DUTY_STEPS; k++)
        begin
            d = (k + off) % DUTY_STEPS;
            irq_seen = 0;
            @(posedge ref_clk);
            duty <= d[DUTY_W-1:0];
            od_en <= 1'b1;
            {irq_a, irq_d} <= 2'($random(seed));
            // With automatic mode off, stirred sensor pins must not matter.
            if (k != 0)
                {near, cool, intr, strobe[3]} <= 4'($random(seed));
            tick(1);
            wait_hot(1'b0, 3);
            if (k == 0)
            begin
                @(posedge ref_clk);
                intr <= 1'b1;
                tick(4);
                check("intr while hot", intr_pend, 1'b1);
                check("snoop while hot", snoop_resp, 1'b1);
                @(posedge ref_clk);
                intr <= 1'b0;
                tick(4);
                pulse(3);
                check("intr cleared", intr_pend, 1'b0);
            end
            tick($unsigned($random(seed)) % 50);
            measure(d == 0 ? 4 : d);
            @(posedge ref_clk);
            od_en <= 1'b0;
            tick(1);
            wait_hot(1'b1, 4);
            tick(2);
            check("hot irq count", irq_seen, int'(irq_a) + int'(irq_d));
        end
        @(posedge ref_clk);
        auto_en <= 1'b1;
        near <= 1'b1;
        tick(1);
        wait_hot(1'b0, 6);
        tick(PERIOD);
        measure(DUTY_AUTO);
        @(posedge ref_clk);
        od_en <= 1'b1;
        duty <= 3'h1;
        tick(PERIOD);
        measure(DUTY_AUTO);
        @(posedge ref_clk);
        od_en <= 1'b0;
        near <= 1'b0;
        cool <= 1'b1;
        tick(HYST);
        check("hysteresis hold", hot_n, 1'b0);
        wait_hot(1'b1, 10);
        enter_sleep();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        tick(3);
        check("reset in sleep", power_state, ST_NORMAL);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(6);
        check("after reset", power_state, ST_NORMAL);
        @(posedge ref_clk);
        trip <= 1'b1;
        tick(5);
        check("trip", {shut_n, clk_en}, 2'h0);
        @(posedge ref_clk);
        trip <= 1'b0;
        tick(20);
        check("trip sticky", shut_n, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        tick(2);
        check("trip cleared", shut_n, 1'b1);
        conclude();
    end
endmodule
